// [rtl/pctim_map.vh]
`ifndef PCTIM_MAP_VH
`define PCTIM_MAP_VH
// Channel stride and offsets inside a channel (byte addresses)
`define PCTIM_CH_STRIDE 8'h40
`define PCTIM_OFF_CTRL 6'h00
`define PCTIM_OFF_IOC 6'h04
`define PCTIM_OFF_IEN 6'h08
`define PCTIM_OFF_STAT 6'h0C
`define PCTIM_OFF_CNT 6'h10
`define PCTIM_OFF_GRA 6'h14
`define PCTIM_OFF_GRB 6'h18
`define PCTIM_OFF_GRC 6'h1C
`define PCTIM_OFF_GRD 6'h20
// Control register fields
`define PCTIM_CTRL_RUN 0
`define PCTIM_CTRL_PHASE 1
`define PCTIM_CTRL_VAR_LO 2
`define PCTIM_CTRL_VAR_HI 3
// Status and enable bit positions (match flags A..D in bits 0..3)
`define PCTIM_ST_OVF 4
`define PCTIM_ST_UNF 5
`define PCTIM_ST_DIR 7
// Phase count variants in the control field
`define PCTIM_VAR1 2'h0
`define PCTIM_VAR2 2'h1
`define PCTIM_VAR3 2'h2
`define PCTIM_VAR4 2'h3
// Output action codes per general register
`define PCTIM_IO_HOLD 2'h0
`define PCTIM_IO_LOW 2'h1
`define PCTIM_IO_HIGH 2'h2
`define PCTIM_IO_TOGGLE 2'h3
// Reset values
`define PCTIM_RST_REG8 8'h00
`define PCTIM_RST_CNT 16'h0000
`define PCTIM_RST_GR 16'hFFFF
`define PCTIM_CNT_MAX 16'hFFFF
`define PCTIM_CNT_MIN 16'h0000
`endif

// [rtl/pctim_top.v]
// Contract
// - Variant 2: A falling with B high counts up, with B low down.
// - Variant 3: A falling, B high up; B falling, A high down.
// - Variant 4: A edges ignored; B edge against A level sets direction.
// - Channel 1 uses pins A and B; channel 2 uses pins C and D.
// - Match, overflow, underflow sources each have own flag and enable.
// - Event sets flag; request follows flag and enable; clearing drops it.
// - Fixed order within channel A..D, overflow, underflow; channel 0 first.
// - Eight match sources: four on channel 0, two on channels 1 and 2.
// - One overflow source per channel, three in total.
// - Underflow sources only on channels 1 and 2.
// - Only the four channel 0 match sources may request DMA.
// - Match fires when the counter leaves the value equal to the register.
// - On match the output pin takes the level chosen in io control.
// - No second match until the next counter clock tick.
// - Variant 1 counts every edge of both phases, direction by phase lead.
// - Phase mode takes pin edges as count source, ignoring the run clock.
// - Overflow sets on up-count wrap, underflow on down-count wrap.
// - A readable direction flag shows the last count direction.
`timescale 1ns/1ps
`include "pctim_map.vh"
`default_nettype none
module pctim_top (
  // Clock and reset
  input wire CLK,
  input wire RSTN,
  // Avalon-MM slave
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // External phase pins A, B, C, D in bits 0..3
  input wire [3:0] EXT_CLOCK_IN,
  // Compare output pins, one per general register
  output reg [7:0] COMPARE_OUTPUT_PIN,
  // Interrupt requests in priority order, bit 0 highest
  output reg [12:0] IRQ_REQ,
  output reg IRQ_ANY,
  output reg [3:0] IRQ_TOP,
  // DMA requests and acknowledges, channel 0 registers A..D
  output reg [3:0] DMA_REQ,
  input wire [3:0] DMA_ACK
);

  // Register state
  reg [23:0] ctrl_r;
  reg [23:0] ioc_r;
  reg [23:0] ien_r;
  reg [47:0] cnt_r;
  reg [127:0] gr_r;
  reg [7:0] mflag_r;
  reg [2:0] ovf_r;
  reg [2:0] unf_r;
  reg [2:0] dir_r;
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg [3:0] sync3_r;
  reg [3:0] filt_r;
  reg [3:0] prev_r;
  reg [31:0] rdata_nxt;
  reg [3:0] top_nxt;
  integer i;
  // Separate index for the clocked loop, so each variable has one writer
  integer j;

  wire [47:0] cnt_nxt;
  wire [7:0] mflag_nxt;
  wire [2:0] ovf_nxt;
  wire [2:0] unf_nxt;
  wire [2:0] dir_nxt;
  wire [7:0] pin_nxt;
  wire [23:0] stat_view;
  wire [12:0] req_vec;
  wire [3:0] rise;
  wire [3:0] fall;

  // Bus decode; a write lands at the edge where waitrequest is low
  wire req = AVS_READ | AVS_WRITE;
  wire wr_go = AVS_WRITE & ~AVS_WAITREQUEST;
  wire [1:0] sel_ch = AVS_ADDRESS[7:6];
  wire [5:0] sel_off = AVS_ADDRESS[5:0];

  // Filtered pin edges after three-stage sampling
  assign rise = filt_r & ~prev_r;
  assign fall = ~filt_r & prev_r;

  // Per-channel counting, flags and status view
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_ch
      // Pin pair of this channel: A and B for 1, C and D for 2
      localparam integer PA = (c == 2) ? 2 : 0;
      localparam integer PB = PA + 1;
      wire run = ctrl_r[8*c+`PCTIM_CTRL_RUN];
      wire phase = (c != 0) & ctrl_r[8*c+`PCTIM_CTRL_PHASE];
      wire [1:0] pvar = ctrl_r[8*c+`PCTIM_CTRL_VAR_HI:8*c+`PCTIM_CTRL_VAR_LO];
      wire a = filt_r[PA];
      wire b = filt_r[PB];
      wire ar = rise[PA];
      wire af = fall[PA];
      wire br = rise[PB];
      wire bf = fall[PB];
      wire [15:0] cnt = cnt_r[16*c+15:16*c];
      reg pu;
      reg pd;
      // Phase decode tables
      always @* begin
        case (pvar)
          `PCTIM_VAR1: begin
            pu = (a & br) | (~a & bf) | (ar & ~b) | (af & b);
            pd = (a & bf) | (~a & br) | (ar & b) | (af & ~b);
          end
          `PCTIM_VAR2: begin
            pu = af & b;
            pd = af & ~b;
          end
          `PCTIM_VAR3: begin
            pu = af & b;
            pd = bf & a;
          end
          `PCTIM_VAR4: begin
            pu = (br & a) | (bf & ~a);
            pd = (bf & a) | (br & ~a);
          end
          default: begin
            pu = 1'b0;
            pd = 1'b0;
          end
        endcase
      end
      // Count source: pin edges in phase mode, otherwise every clock while run is set
      wire up = phase ? (pu & ~pd) : run;
      wire dn = phase & pd & ~pu;
      wire cnt_wr = wr_go & (sel_ch == c) & (sel_off == `PCTIM_OFF_CNT);
      wire tick = (up | dn) & ~cnt_wr;
      wire st_wr = wr_go & (sel_ch == c) & (sel_off == `PCTIM_OFF_STAT);
      assign cnt_nxt[16*c+15:16*c] = cnt_wr ? AVS_WRITEDATA[15:0] :
        up ? cnt + 16'h0001 : dn ? cnt - 16'h0001 : cnt;
      // Wrap flags; a counter write blocks the wrap
      wire ovf_set = tick & up & (cnt == `PCTIM_CNT_MAX);
      wire unf_set = (c != 0) & tick & dn & (cnt == `PCTIM_CNT_MIN);
      assign ovf_nxt[c] = ovf_set |
        (ovf_r[c] & ~(st_wr & ~AVS_WRITEDATA[`PCTIM_ST_OVF]));
      assign unf_nxt[c] = unf_set |
        (unf_r[c] & ~(st_wr & ~AVS_WRITEDATA[`PCTIM_ST_UNF]));
      assign dir_nxt[c] = dn ? 1'b0 : (up ? 1'b1 : dir_r[c]);
      assign stat_view[8*c+7:8*c] = {dir_r[c], 1'b0, unf_r[c], ovf_r[c],
        (c == 0) ? mflag_r[3:0] :
        (c == 1) ? {2'h0, mflag_r[5:4]} : {2'h0, mflag_r[7:6]}};
    end
  endgenerate

  // Per general register: compare match, flag and output pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_gr
      localparam integer CH = (g < 4) ? 0 : ((g < 6) ? 1 : 2);
      localparam integer LT = (g < 4) ? g : ((g - 4) % 2);
      wire [15:0] cnt = cnt_r[16*CH+15:16*CH];
      wire [1:0] act = ioc_r[8*CH+2*LT+1:8*CH+2*LT];
      wire run = ctrl_r[8*CH+`PCTIM_CTRL_RUN];
      wire phase = (CH != 0) & ctrl_r[8*CH+`PCTIM_CTRL_PHASE];
      wire moved = (cnt_nxt[16*CH+15:16*CH] != cnt) | (run & ~phase);
      wire gr_wr = wr_go & (sel_ch == CH) &
        (sel_off == (`PCTIM_OFF_GRA + 6'h04 * LT[5:0]));
      // Match at the update leaving the equal value; one per tick
      wire match = moved & (cnt == gr_r[16*g+15:16*g]) &
        ~gr_wr;
      wire st_clr = wr_go & (sel_ch == CH) &
        (sel_off == `PCTIM_OFF_STAT) & ~AVS_WRITEDATA[LT];
      wire dma_clr = (g < 4) & DMA_ACK[LT];
      assign mflag_nxt[g] = match |
        (mflag_r[g] & ~(st_clr | dma_clr));
      assign pin_nxt[g] = ~match ? COMPARE_OUTPUT_PIN[g] :
        (act == `PCTIM_IO_LOW) ? 1'b0 :
        (act == `PCTIM_IO_HIGH) ? 1'b1 :
        (act == `PCTIM_IO_TOGGLE) ? ~COMPARE_OUTPUT_PIN[g] :
        COMPARE_OUTPUT_PIN[g];
    end
  endgenerate

  // Requests in fixed priority order, each gated by its enable
  assign req_vec = {
    unf_r[2] & ien_r[16+`PCTIM_ST_UNF], ovf_r[2] & ien_r[16+`PCTIM_ST_OVF],
    mflag_r[7] & ien_r[17], mflag_r[6] & ien_r[16],
    unf_r[1] & ien_r[8+`PCTIM_ST_UNF], ovf_r[1] & ien_r[8+`PCTIM_ST_OVF],
    mflag_r[5] & ien_r[9], mflag_r[4] & ien_r[8],
    ovf_r[0] & ien_r[`PCTIM_ST_OVF],
    mflag_r[3:0] & ien_r[3:0]};

  // Highest pending source, lowest index wins
  always @* begin
    top_nxt = 4'h0;
    for (i = 12; i >= 0; i = i - 1) begin
      if (req_vec[i]) begin
        top_nxt = i[3:0];
      end
    end
  end

  // Register read mux; unmapped locations read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (sel_ch != 2'h3) begin
      case (sel_off)
        `PCTIM_OFF_CTRL: rdata_nxt[7:0] = ctrl_r[8*sel_ch+:8];
        `PCTIM_OFF_IOC: rdata_nxt[7:0] = ioc_r[8*sel_ch+:8];
        `PCTIM_OFF_IEN: rdata_nxt[7:0] = ien_r[8*sel_ch+:8];
        `PCTIM_OFF_STAT: rdata_nxt[7:0] = stat_view[8*sel_ch+:8];
        `PCTIM_OFF_CNT: rdata_nxt[15:0] = cnt_r[16*sel_ch+:16];
        `PCTIM_OFF_GRA: rdata_nxt[15:0] =
          gr_r[16*((sel_ch == 2'h0) ? 0 : 2 + 2*sel_ch)+:16];
        `PCTIM_OFF_GRB: rdata_nxt[15:0] =
          gr_r[16*((sel_ch == 2'h0) ? 1 : 3 + 2*sel_ch)+:16];
        `PCTIM_OFF_GRC: if (sel_ch == 2'h0) rdata_nxt[15:0] = gr_r[47:32];
        `PCTIM_OFF_GRD: if (sel_ch == 2'h0) rdata_nxt[15:0] = gr_r[63:48];
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // All state registers
  always @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_r <= {3{`PCTIM_RST_REG8}};
      ioc_r <= {3{`PCTIM_RST_REG8}};
      ien_r <= {3{`PCTIM_RST_REG8}};
      cnt_r <= {3{`PCTIM_RST_CNT}};
      gr_r <= {8{`PCTIM_RST_GR}};
      mflag_r <= 8'h00;
      ovf_r <= 3'h0;
      unf_r <= 3'h0;
      dir_r <= 3'h7;
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
      filt_r <= 4'h0;
      prev_r <= 4'h0;
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
      COMPARE_OUTPUT_PIN <= 8'h00;
      IRQ_REQ <= 13'h0000;
      IRQ_ANY <= 1'b0;
      IRQ_TOP <= 4'h0;
      DMA_REQ <= 4'h0;
    end else begin
      // Pin sampling; a level counts once stages two and three agree
      sync1_r <= EXT_CLOCK_IN;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (j = 0; j < 4; j = j + 1) begin
        if (sync2_r[j] == sync3_r[j]) begin
          filt_r[j] <= sync3_r[j];
        end
      end
      prev_r <= filt_r;
      // One wait cycle, then answer with waitrequest low
      if (req && AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b0;
      end else begin
        AVS_WAITREQUEST <= 1'b1;
      end
      // Read data moves only on a read answer and holds across writes
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= rdata_nxt;
      end
      // Software writes of the configuration registers
      if (wr_go && sel_ch != 2'h3) begin
        case (sel_off)
          `PCTIM_OFF_CTRL: ctrl_r[8*sel_ch+:8] <= AVS_WRITEDATA[7:0];
          `PCTIM_OFF_IOC: ioc_r[8*sel_ch+:8] <= AVS_WRITEDATA[7:0];
          `PCTIM_OFF_IEN: ien_r[8*sel_ch+:8] <= AVS_WRITEDATA[7:0];
          `PCTIM_OFF_GRA:
            gr_r[16*((sel_ch == 2'h0) ? 0 : 2 + 2*sel_ch)+:16] <=
              AVS_WRITEDATA[15:0];
          `PCTIM_OFF_GRB:
            gr_r[16*((sel_ch == 2'h0) ? 1 : 3 + 2*sel_ch)+:16] <=
              AVS_WRITEDATA[15:0];
          `PCTIM_OFF_GRC: if (sel_ch == 2'h0) gr_r[47:32] <= AVS_WRITEDATA[15:0];
          `PCTIM_OFF_GRD: if (sel_ch == 2'h0) gr_r[63:48] <= AVS_WRITEDATA[15:0];
          default: ;
        endcase
      end
      // Counters, flags and pins
      cnt_r <= cnt_nxt;
      mflag_r <= mflag_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      dir_r <= dir_nxt;
      COMPARE_OUTPUT_PIN <= pin_nxt;
      IRQ_REQ <= req_vec;
      IRQ_ANY <= |req_vec;
      IRQ_TOP <= top_nxt;
      DMA_REQ <= req_vec[3:0];
    end
  end

endmodule // pctim_top
`default_nettype wire

// [dv/pctim_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module pctim_chk (
  // Clock and reset
  input wire CLK,
  input wire RSTN,
  // Register bus
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Requests
  input wire [12:0] IRQ_REQ,
  input wire IRQ_ANY,
  input wire [3:0] IRQ_TOP,
  input wire [3:0] DMA_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Bus answer comes after exactly one wait cycle and stands one cycle
  a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus answer late");
  a_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("bus answer too long");
  a_wait_idle: assert property (!(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("answer without request");
  a_read_hold: assert property ($changed(AVS_READDATA)
    |-> !AVS_WAITREQUEST && AVS_READ) else $error("read data moved");
  // Request outputs against each other
  a_dma_mirror: assert property (DMA_REQ == IRQ_REQ[3:0])
    else $error("dma request not channel 0 match");
  a_any_or: assert property (IRQ_ANY == (|IRQ_REQ))
    else $error("any request mismatch");
  a_top_none: assert property (!IRQ_ANY |-> IRQ_TOP == 4'h0)
    else $error("top index without request");
  a_top_first: assert property (IRQ_ANY |-> IRQ_TOP < 4'hD
    && IRQ_REQ[IRQ_TOP] && (IRQ_REQ & ((13'h0001 << IRQ_TOP) - 13'h0001))
    == 13'h0000) else $error("top index not highest");
endmodule // pctim_chk
bind pctim_top pctim_chk u_chk (.CLK(CLK), .RSTN(RSTN),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ_REQ(IRQ_REQ), .IRQ_ANY(IRQ_ANY),
  .IRQ_TOP(IRQ_TOP), .DMA_REQ(DMA_REQ));
`default_nettype wire

// [dv/pctim_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module pctim_encoder (
  // Clock
  input wire logic CLK,
  // Phase pins A, B, C, D
  output logic [3:0] PINS
);
  // Pins idle low until the first move
  initial PINS = 4'h0;
  // Step the phases, then hold well past the three-sample filter
  task move(input logic [3:0] lvl);
    @(posedge CLK);
    PINS <= lvl;
    repeat (8) @(posedge CLK);
  endtask
endmodule // pctim_encoder
`default_nettype wire

// [dv/test_pctim_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pctim_top;
  logic clk, rstn, rd_en, wr_en;
  logic [7:0] addr;
  logic [31:0] wdata, q;
  logic [3:0] ack;
  wire [31:0] rdata;
  wire waitreq, irq_any;
  wire [3:0] ext, irq_top, dma_req;
  wire [7:0] pin;
  wire [12:0] irq;
  int err_count, total_checks, i, j;
  logic [3:0] mv [8] = '{4'h2, 4'h3, 4'h2, 4'h3, 4'h1, 4'h0, 4'h1, 4'h0};
  // One turn of pins C and D with C leading, then the reverse turn
  logic [3:0] fw [4] = '{4'h4, 4'hC, 4'h8, 4'h0};
  logic [3:0] rv [4] = '{4'h8, 4'hC, 4'h4, 4'h0};
  // Channel 2 control per pass (variants 4, 1, 3) and expected counts
  logic [31:0] vc [3] = '{32'h0000000E, 32'h00000002, 32'h0000000A};
  logic [31:0] ef [3] = '{32'h00000002, 32'h00000004, 32'h00000000};
  logic [31:0] eb [3] = '{32'h00000000, 32'h00000000, 32'h0000FFFF};

  pctim_top dut (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .EXT_CLOCK_IN(ext),
    .COMPARE_OUTPUT_PIN(pin), .IRQ_REQ(irq), .IRQ_ANY(irq_any),
    .IRQ_TOP(irq_top), .DMA_REQ(dma_req), .DMA_ACK(ack));
  pctim_encoder enc (.CLK(clk), .PINS(ext));

  // Verdict and end of run
  task report_and_stop();
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Bounded wait for one request bit
  task wait_irq(input int b);
    for (int n = 0; n < 60 && irq[b] !== 1'b1; n++) @(negedge clk);
  endtask

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rstn = 1'b0; rd_en = 1'b0; wr_en = 1'b0; addr = 8'h00;
    wdata = 32'h0; ack = 4'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h14, 32'h0000FFFF);
    rd(8'h4C, 32'h00000080);
    rd(8'hC0, 32'h00000000);
    // Channel 0 match A sets output high and raises request and dma
    acc(1'b1, 8'h14, 32'h5); acc(1'b1, 8'h04, 32'h2);
    acc(1'b1, 8'h08, 32'h1); acc(1'b1, 8'h00, 32'h1);
    wait_irq(0);
    acc(1'b1, 8'h00, 32'h0);
    chk(pin[0], 1'b1);
    chk({irq_any, dma_req[0], irq_top}, 6'h30);
    rd(8'h0C, 32'h00000081);
    @(posedge clk) ack <= 4'h1;
    @(posedge clk) ack <= 4'h0;
    repeat (2) @(negedge clk);
    chk(irq[0], 1'b0);
    rd(8'h0C, 32'h00000080);
    // Second match toggles the pin; software clear drops request
    acc(1'b1, 8'h04, 32'h3); acc(1'b1, 8'h10, 32'h0);
    acc(1'b1, 8'h00, 32'h1);
    wait_irq(0);
    acc(1'b1, 8'h00, 32'h0);
    chk(pin[0], 1'b0);
    acc(1'b1, 8'h0C, 32'h0);
    repeat (2) @(negedge clk);
    chk(irq[0], 1'b0);
    // Channel 1 variant 2 on pins A and B, down through zero
    acc(1'b1, 8'h48, 32'h20); acc(1'b1, 8'h54, 32'h1);
    acc(1'b1, 8'h40, 32'h6);
    for (i = 0; i < 8; i++) begin
      enc.move(mv[i]);
      if (i == 2) rd(8'h50, 32'h1);
      if (i == 2) rd(8'h4C, 32'h80);
      if (i == 5) rd(8'h50, 32'h0);
      if (i == 5) rd(8'h4C, 32'h01);
    end
    rd(8'h50, 32'h0000FFFF);
    rd(8'h4C, 32'h00000021);
    chk({irq[8], irq_top}, 5'h18);
    // Channel 2 on pins C and D, one turn each way in variants 4, 1, 3
    acc(1'b1, 8'h88, 32'h30);
    for (i = 0; i < 3; i++) begin
      acc(1'b1, 8'h80, vc[i]);
      if (i == 2) acc(1'b1, 8'h90, 32'hFFFF);
      for (j = 0; j < 4; j++) enc.move(fw[j]);
      rd(8'h90, ef[i]);
      for (j = 0; j < 4; j++) enc.move(rv[j]);
      rd(8'h90, eb[i]);
    end
    rd(8'h8C, 32'h00000033);
    chk({irq[12:11], irq_top}, 6'h38);
    acc(1'b1, 8'h4C, 32'h0);
    repeat (2) @(negedge clk);
    chk({irq[8], irq_top}, 5'h0B);
    report_and_stop();
  end
endmodule // test_pctim_top
`default_nettype wire
